// ==== rtl/beh_acceptor.sv ====
// module: acceptor end of the single-bill escrow handshake
// Behaviour
// [RL1] escrow handshake only in parallel, pulse, binary
// [RL2] host holds escrow low while idle
// [RL3] 100ms credit pulse on bill's channel
// [RL4] stack only after host confirms vend
// [RL5] return bill if no escrow within 30s
// [RL6] escrow high: stack, second 100ms pulse
// [RL7] host aborts if no final pulse 30s
// [RL8] host drops escrow after vend completes
// [RL9] channel inhibit high aborts, return at once
// [RL10] channels above 4: all inhibits abort
// [RL11] bill pulled out: refuse bills 45s
// [RL12] timers run from millisecond tick, reset cleared
`timescale 1ns/1ns
module beh_acceptor
#(
    // millisecond tick period in clock cycles; a shorter period scales every timer together
    parameter int TICK_CYCLES = beh_pkg::BEH_TICK_CYCLES
)
(
    // clock and reset
    input  wire logic                         ref_clk_in,
    input  wire logic                         sys_rst_in,
    // configuration
    input  wire beh_pkg::beh_mode_t           mode_in,
    // validator side
    input  wire logic                         bill_valid_in,
    input  wire logic [beh_pkg::BEH_CHAN_W-1:0] bill_chan_in,
    input  wire logic                         bill_removed_in,
    output logic                              bill_ready_out,
    output logic                              stack_out,
    output logic                              return_out,
    output logic                              out_of_service_out,
    // host lines
    beh_if.acceptor                           link
);
    import beh_pkg::*;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic                   esc_s1;
    logic                   esc_s2;
    logic [BEH_NUM_INH-1:0] inh_s1;
    logic [BEH_NUM_INH-1:0] inh_s2;

    // host lines come from another machine, so two flops each
    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            esc_s1 <= 1'b0;
            esc_s2 <= 1'b0;
            inh_s1 <= 4'h0;
            inh_s2 <= 4'h0;
        end
        else
        begin
            esc_s1 <= link.escrow;
            esc_s2 <= esc_s1;
            inh_s1 <= link.inhibit;
            inh_s2 <= inh_s1;
        end
    end

    // ----------------------------------------
    // millisecond tick
    // ----------------------------------------
    localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);

    logic [16:0] tick_cnt;
    logic        ms_tick;

    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            tick_cnt <= 17'h0;
            ms_tick  <= 1'b0;
        end
        else if (tick_cnt == TICK_LAST)
        begin
            tick_cnt <= 17'h0; // [RL12]
            ms_tick  <= 1'b1;
        end
        else
        begin
            tick_cnt <= tick_cnt + 17'h1;
            ms_tick  <= 1'b0;
        end
    end

    // ----------------------------------------
    // escrow state machine
    // ----------------------------------------
    beh_dev_state_t          state;
    logic [BEH_MS_W-1:0]     pulse_ms;
    logic [BEH_MS_W-1:0]     wait_ms;
    logic [BEH_CHAN_W-1:0]   chan;
    logic                    esc_on;
    logic                    abort;

    assign esc_on = beh_escrow_mode(mode_in); // [RL1]
    assign abort  = beh_abort_hit(chan, inh_s2); // [RL9] [RL10]

    // one process owns state, timers and the latched channel
    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            state    <= BEH_DEV_IDLE;
            pulse_ms <= '0; // [RL12]
            wait_ms  <= '0;
            chan     <= '0;
        end
        else
        begin
            case (state)
                BEH_DEV_IDLE:
                begin
                    // escrow still high from a previous vend: wait for it to drop
                    if (esc_on && bill_valid_in && !esc_s2) // [RL2] [RL8]
                    begin
                        chan     <= bill_chan_in;
                        pulse_ms <= '0;
                        wait_ms  <= '0;
                        state    <= BEH_DEV_PULSE1;
                    end
                end
                BEH_DEV_PULSE1, BEH_DEV_HOLD:
                begin
                    if (ms_tick)
                    begin
                        wait_ms <= wait_ms + 16'h1;
                        if (pulse_ms != 16'(BEH_PULSE_MS))
                            pulse_ms <= pulse_ms + 16'h1;
                    end
                    if (bill_removed_in)
                    begin
                        wait_ms <= '0;
                        state   <= BEH_DEV_OOS; // [RL11]
                    end
                    else if (abort)
                        state <= BEH_DEV_RETURN; // [RL9] [RL10]
                    else if (wait_ms >= 16'(BEH_ESCROW_MS))
                        state <= BEH_DEV_RETURN; // [RL5]
                    else if (state == BEH_DEV_PULSE1 && pulse_ms == 16'(BEH_PULSE_MS))
                        state <= BEH_DEV_HOLD; // [RL3]
                    else if (state == BEH_DEV_HOLD && esc_s2)
                    begin
                        pulse_ms <= '0;
                        state    <= BEH_DEV_PULSE2; // [RL4] [RL6]
                    end
                end
                BEH_DEV_PULSE2:
                begin
                    if (ms_tick)
                        pulse_ms <= pulse_ms + 16'h1;
                    if (pulse_ms == 16'(BEH_PULSE_MS))
                        state <= BEH_DEV_IDLE; // [RL6]
                end
                BEH_DEV_RETURN:
                    state <= BEH_DEV_IDLE;
                BEH_DEV_OOS:
                begin
                    if (ms_tick)
                        wait_ms <= wait_ms + 16'h1;
                    if (wait_ms >= 16'(BEH_OOS_MS))
                        state <= BEH_DEV_IDLE; // [RL11]
                end
                default:
                    state <= BEH_DEV_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    logic [BEH_NUM_CHAN-1:0] next_credit;

    // credit is high only while a pulse window is open
    always_comb
    begin
        next_credit = '0;
        if (state == BEH_DEV_PULSE1 || state == BEH_DEV_PULSE2)
            next_credit[chan] = 1'b1; // [RL3] [RL6]
    end

    // registered outputs; stack strobes once on entry to the second pulse
    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            link.credit        <= '0;
            stack_out          <= 1'b0;
            return_out         <= 1'b0;
            out_of_service_out <= 1'b0;
        end
        else
        begin
            link.credit        <= next_credit;
            stack_out          <= (state == BEH_DEV_HOLD) && esc_s2 && !abort
                                  && !bill_removed_in
                                  && (wait_ms < 16'(BEH_ESCROW_MS)); // [RL4]
            return_out         <= (state == BEH_DEV_RETURN);
            out_of_service_out <= (state == BEH_DEV_OOS); // [RL11]
        end
    end

    // handshake output: a new bill may be offered only when idle and not escrow-high
    assign bill_ready_out = (state == BEH_DEV_IDLE) && esc_on && !esc_s2;

endmodule

// ==== rtl/beh_pkg.sv ====
// package: shared constants and types for the bill escrow handshake
package beh_pkg;

    // ----------------------------------------
    // interface modes
    // ----------------------------------------
    typedef enum logic [2:0]
    {
        BEH_MODE_PARALLEL = 3'h0,
        BEH_MODE_PULSE    = 3'h1,
        BEH_MODE_BINARY   = 3'h2,
        BEH_MODE_SERIAL   = 3'h3,
        BEH_MODE_MULTIDROP = 3'h4
    } beh_mode_t;

    // ----------------------------------------
    // widths and timing
    // ----------------------------------------
    localparam int          BEH_NUM_CHAN     = 8;
    localparam int          BEH_NUM_INH      = 4;
    localparam int          BEH_CHAN_W       = 3;
    localparam int          BEH_CLK_HZ       = 125000000;
    localparam int          BEH_TICK_CYCLES  = BEH_CLK_HZ / 1000;
    localparam int          BEH_PULSE_MS     = 100;
    localparam int          BEH_ESCROW_S     = 30;
    localparam int          BEH_OOS_S        = 45;
    localparam int          BEH_ESCROW_MS    = BEH_ESCROW_S * 1000;
    localparam int          BEH_OOS_MS       = BEH_OOS_S * 1000;
    localparam int          BEH_MS_W         = 16;
    localparam logic [16:0] BEH_TICK_LAST    = 17'(BEH_TICK_CYCLES - 1);

    // ----------------------------------------
    // acceptor states (gray along the usual path)
    // ----------------------------------------
    typedef enum logic [2:0]
    {
        BEH_DEV_IDLE    = 3'h0,
        BEH_DEV_PULSE1  = 3'h1,
        BEH_DEV_HOLD    = 3'h3,
        BEH_DEV_PULSE2  = 3'h2,
        BEH_DEV_RETURN  = 3'h6,
        BEH_DEV_OOS     = 3'h7
    } beh_dev_state_t;

    // host states
    typedef enum logic [2:0]
    {
        BEH_HST_IDLE    = 3'h0,
        BEH_HST_OFFER   = 3'h1,
        BEH_HST_WAIT    = 3'h3,
        BEH_HST_DONE    = 3'h2,
        BEH_HST_ABORT   = 3'h6
    } beh_hst_state_t;

    // true in the modes that use the escrow line
    function automatic logic beh_escrow_mode(input beh_mode_t m);
        return (m == BEH_MODE_PARALLEL) || (m == BEH_MODE_PULSE) || (m == BEH_MODE_BINARY);
    endfunction

    // abort pattern for a channel: own inhibit for 1..4, all four above
    function automatic logic beh_abort_hit(input logic [BEH_CHAN_W-1:0] ch,
                                           input logic [BEH_NUM_INH-1:0] inh);
        if (ch < 3'h4)
            return inh[ch[1:0]];
        else
            return &inh;
    endfunction

endpackage

// ==== rtl/beh_if.sv ====
// interface: discrete lines between bill acceptor and host
`timescale 1ns/1ns
interface beh_if;
    import beh_pkg::*;

    logic                    escrow;
    logic [BEH_NUM_CHAN-1:0] credit;
    logic [BEH_NUM_INH-1:0]  inhibit;

    modport acceptor
    (
        input  escrow,
        input  inhibit,
        output credit
    );

    modport host
    (
        output escrow,
        output inhibit,
        input  credit
    );
endinterface

// ==== rtl/beh_host.sv ====
// module: host end of the single-bill escrow handshake
`timescale 1ns/1ns
module beh_host
#(
    // millisecond tick period in clock cycles; must match the acceptor's
    parameter int TICK_CYCLES = beh_pkg::BEH_TICK_CYCLES
)
(
    // clock and reset
    input  wire logic                           ref_clk_in,
    input  wire logic                           sys_rst_in,
    // user side
    input  wire logic                           vend_ok_in,
    input  wire logic                           abort_in,
    output logic                                credit_seen_out,
    output logic [beh_pkg::BEH_CHAN_W-1:0]      credit_chan_out,
    output logic                                vend_done_out,
    output logic                                vend_abort_out,
    // acceptor lines
    beh_if.host                                 link
);
    import beh_pkg::*;

    // ----------------------------------------
    // synchronisers and tick
    // ----------------------------------------
    logic [BEH_NUM_CHAN-1:0] cr_s1;
    logic [BEH_NUM_CHAN-1:0] cr_s2;
    logic [BEH_NUM_CHAN-1:0] cr_d;
    logic [16:0]             tick_cnt;
    logic                    ms_tick;

    localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);

    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            cr_s1 <= '0;
            cr_s2 <= '0;
            cr_d  <= '0;
        end
        else
        begin
            cr_s1 <= link.credit;
            cr_s2 <= cr_s1;
            cr_d  <= cr_s2;
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in || tick_cnt == TICK_LAST)
            tick_cnt <= 17'h0;
        else
            tick_cnt <= tick_cnt + 17'h1;
    end
    assign ms_tick = (tick_cnt == TICK_LAST);

    // ----------------------------------------
    // vend sequence
    // ----------------------------------------
    beh_hst_state_t        state;
    logic [BEH_MS_W-1:0]   wait_ms;
    logic [BEH_CHAN_W-1:0] chan;
    logic                  rise;
    logic [BEH_CHAN_W-1:0] rise_ch;

    // lowest channel whose credit line just went high
    always_comb
    begin
        rise    = 1'b0;
        rise_ch = '0;
        for (int i = BEH_NUM_CHAN - 1; i >= 0; i--)
            if (cr_s2[i] && !cr_d[i])
            begin
                rise    = 1'b1;
                rise_ch = BEH_CHAN_W'(i);
            end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            state   <= BEH_HST_IDLE;
            wait_ms <= '0;
            chan    <= '0;
        end
        else
        begin
            case (state)
                BEH_HST_IDLE:
                    if (rise)
                    begin
                        chan    <= rise_ch;
                        wait_ms <= '0;
                        state   <= BEH_HST_OFFER;
                    end
                BEH_HST_OFFER:
                begin
                    if (ms_tick)
                        wait_ms <= wait_ms + 16'h1;
                    if (abort_in || wait_ms >= 16'(BEH_ESCROW_MS))
                        state <= BEH_HST_ABORT; // [RL9]
                    else if (vend_ok_in && !cr_s2[chan])
                    begin
                        wait_ms <= '0;
                        state   <= BEH_HST_WAIT;
                    end
                end
                BEH_HST_WAIT:
                begin
                    if (ms_tick)
                        wait_ms <= wait_ms + 16'h1;
                    if (rise && rise_ch == chan)
                        state <= BEH_HST_DONE;
                    else if (wait_ms >= 16'(BEH_ESCROW_MS))
                        state <= BEH_HST_ABORT; // [RL7]
                end
                BEH_HST_DONE:
                    if (!cr_s2[chan])
                        state <= BEH_HST_IDLE; // [RL8]
                BEH_HST_ABORT:
                    if (!cr_s2[chan])
                        state <= BEH_HST_IDLE;
                default:
                    state <= BEH_HST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // line drivers and user outputs
    // ----------------------------------------
    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            link.escrow     <= 1'b0;
            link.inhibit    <= '0;
            credit_seen_out <= 1'b0;
            credit_chan_out <= '0;
            vend_done_out   <= 1'b0;
            vend_abort_out  <= 1'b0;
        end
        else
        begin
            // escrow high only while confirming; low when idle
            link.escrow     <= (state == BEH_HST_WAIT); // [RL2] [RL8]
            link.inhibit    <= '0;
            if (state == BEH_HST_ABORT)
            begin
                if (chan < 3'h4)
                    link.inhibit[chan[1:0]] <= 1'b1; // [RL9]
                else
                    link.inhibit <= 4'hF; // [RL10]
            end
            credit_seen_out <= (state == BEH_HST_IDLE) && rise;
            credit_chan_out <= (state == BEH_HST_IDLE && rise) ? rise_ch : credit_chan_out;
            vend_done_out   <= (state == BEH_HST_WAIT) && rise && rise_ch == chan;
            vend_abort_out  <= (state != BEH_HST_ABORT) && (
                               (state == BEH_HST_OFFER &&
                                (abort_in || wait_ms >= 16'(BEH_ESCROW_MS))) ||
                               (state == BEH_HST_WAIT && !(rise && rise_ch == chan) &&
                                wait_ms >= 16'(BEH_ESCROW_MS))); // [RL7]
        end
    end

endmodule

// ==== tb/beh_escrow_assertions.sv ====
// checker: timing relations on the acceptor/host discrete lines
`timescale 1ns/1ns
module beh_escrow_assertions
(
    // clock and reset
    input wire logic                             ref_clk_in,
    input wire logic                             sys_rst_in,
    // link lines
    input wire logic                             escrow,
    input wire logic [beh_pkg::BEH_NUM_CHAN-1:0] credit,
    input wire logic [beh_pkg::BEH_NUM_INH-1:0]  inhibit
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    // ------------------------------------------------
    // properties
    // ------------------------------------------------
    // a single bill means at most one credit line high
    property p_credit_onehot;
        $onehot0(credit);
    endproperty
    a_credit_onehot: assert property (p_credit_onehot) else $error("two credit lines high");

    // a credit pulse holds its channel, no glitching
    property p_pulse_hold;
        $rose(|credit) |=> $stable(credit) [*8];
    endproperty
    a_pulse_hold: assert property (p_pulse_hold) else $error("credit pulse broke early");

    // lines come out of reset quiet
    property p_reset_clear;
        $fell(sys_rst_in) |-> (credit == '0) && (inhibit == '0) && !escrow;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("lines busy after reset");

    // abort patterns: none, own channel, or all four
    property p_inh_pattern;
        (inhibit == '0) || $onehot(inhibit) || (&inhibit);
    endproperty
    a_inh_pattern: assert property (p_inh_pattern) else $error("bad inhibit pattern");

    // host never confirms and aborts at once
    property p_no_conflict;
        !(escrow && (|inhibit));
    endproperty
    a_no_conflict: assert property (p_no_conflict) else $error("escrow and inhibit both high");

    // inhibit released only once credit is gone
    property p_inh_release;
        $fell(|inhibit) |-> (credit == '0);
    endproperty
    a_inh_release: assert property (p_inh_release) else $error("inhibit dropped during credit");

    // escrow raised only after the first pulse has ended
    property p_escrow_rise;
        $rose(escrow) |-> (credit == '0);
    endproperty
    a_escrow_rise: assert property (p_escrow_rise) else $error("escrow raised during pulse");

    // host waits for final acceptance, escrow not a blip
    property p_escrow_hold;
        $rose(escrow) |=> escrow [*4];
    endproperty
    a_escrow_hold: assert property (p_escrow_hold) else $error("escrow dropped too soon");
endmodule

// ==== tb/tb_bill_escrow_handshake.sv ====
// testbench: acceptor and host joined across the escrow interface
`timescale 1ns/1ns
module tb_bill_escrow_handshake;
    import beh_pkg::*;

    // ------------------------------------------------
    // signals
    // ------------------------------------------------
    logic       ref_clk_in      = 1'b0;
    logic       sys_rst_in      = 1'b1;
    beh_mode_t  mode_in         = BEH_MODE_PARALLEL;
    logic       bill_valid_in   = 1'b0;
    logic [2:0] bill_chan_in    = 3'h0;
    logic       bill_removed_in = 1'b0;
    logic       vend_ok_in      = 1'b0;
    logic       abort_in        = 1'b0;
    logic       bill_ready_out, stack_out, return_out, out_of_service_out;
    logic       credit_seen_out, vend_done_out, vend_abort_out;
    logic [2:0] credit_chan_out;
    logic       stack_seen = 1'b0;
    logic       ret_seen   = 1'b0;
    logic       done_seen  = 1'b0;
    logic       abrt_seen  = 1'b0;
    int         fail_count = 0;
    int         tests_run  = 0;
    int         cyc_count  = 0;
    localparam int CYC_LIMIT = 40000;
    // one-cycle tick keeps the 30 s escrow timer inside the run
    localparam int TB_TICK   = 1;

    beh_if link_if ();

    beh_acceptor #(.TICK_CYCLES(TB_TICK)) beh_acceptor_inst (.ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .mode_in(mode_in), .bill_valid_in(bill_valid_in), .bill_chan_in(bill_chan_in),
        .bill_removed_in(bill_removed_in), .bill_ready_out(bill_ready_out),
        .stack_out(stack_out), .return_out(return_out),
        .out_of_service_out(out_of_service_out), .link(link_if));

    beh_host #(.TICK_CYCLES(TB_TICK)) beh_host_inst (.ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .vend_ok_in(vend_ok_in), .abort_in(abort_in), .credit_seen_out(credit_seen_out),
        .credit_chan_out(credit_chan_out), .vend_done_out(vend_done_out),
        .vend_abort_out(vend_abort_out), .link(link_if));

    beh_escrow_assertions beh_escrow_assertions_inst (.ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in), .escrow(link_if.escrow), .credit(link_if.credit),
        .inhibit(link_if.inhibit));

    // ------------------------------------------------
    // clock, pulse catchers, hang guard
    // ------------------------------------------------
    always #4 ref_clk_in = ~ref_clk_in;

    // stack and return are one-cycle pulses, so latch them for later checks
    always @(posedge ref_clk_in)
    begin
        cyc_count++;
        if (stack_out === 1'b1) stack_seen = 1'b1;
        if (return_out === 1'b1) ret_seen = 1'b1;
        if (vend_done_out === 1'b1) done_seen = 1'b1;
        if (vend_abort_out === 1'b1) abrt_seen = 1'b1;
        if (cyc_count == CYC_LIMIT)
        begin
            fail_count++;
            print_verdict();
        end
    end

    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_vec({7'h00, got}, {7'h00, exp});
    endtask

    // reset held ten cycles, then room for the escrow synchroniser
    task automatic do_reset();
        @(negedge ref_clk_in);
        sys_rst_in = 1'b1;
        repeat (10) @(negedge ref_clk_in);
        sys_rst_in = 1'b0;
        stack_seen = 1'b0;
        ret_seen = 1'b0;
        done_seen = 1'b0;
        abrt_seen = 1'b0;
        repeat (3) @(negedge ref_clk_in);
    endtask

    // offer one bill; credit is registered one edge after the bill is taken
    task automatic insert_bill(input logic [2:0] ch);
        int n;
        for (n = 0; n < 20 && bill_ready_out !== 1'b1; n++) @(negedge ref_clk_in);
        chk_bit(bill_ready_out, 1'b1);
        bill_chan_in = ch;
        bill_valid_in = 1'b1;
        @(negedge ref_clk_in);
        bill_valid_in = 1'b0;
        chk_vec(link_if.credit, 8'h00);
        @(negedge ref_clk_in);
        chk_vec(link_if.credit, 8'h01 << ch);
    endtask

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic t_modes();
        int m;
        for (m = 0; m < 5; m++)
        begin
            mode_in = beh_mode_t'(m);
            do_reset();
            chk_bit(bill_ready_out, logic'(m < 3));
            bill_chan_in = 3'h2;
            bill_valid_in = 1'b1;
            @(negedge ref_clk_in);
            bill_valid_in = 1'b0;
            repeat (4) @(negedge ref_clk_in);
            chk_vec(link_if.credit, (m < 3) ? 8'h04 : 8'h00);
        end
        mode_in = BEH_MODE_PARALLEL;
        $display("test modes done");
    endtask

    // every channel: pulse on its own line, host sees it, no stacking
    task automatic t_credit();
        int c, n;
        for (c = 0; c < 8; c++)
        begin
            do_reset();
            insert_bill(3'(c));
            for (n = 0; n < 20 && credit_seen_out !== 1'b1; n++) @(negedge ref_clk_in);
            chk_bit(credit_seen_out, 1'b1);
            chk_vec({5'h00, credit_chan_out}, 8'(c));
            repeat (50) @(negedge ref_clk_in);
            chk_vec(link_if.credit, 8'h01 << c);
            chk_bit(stack_seen, 1'b0);
        end
        $display("test credit done");
    endtask

    // host abort: own inhibit, or all four above channel index 3
    task automatic t_abort(input logic [2:0] ch, input logic [3:0] exp);
        int n;
        do_reset();
        insert_bill(ch);
        abort_in = 1'b1;
        for (n = 0; n < 40 && link_if.inhibit === 4'h0; n++) @(negedge ref_clk_in);
        chk_vec({4'h0, link_if.inhibit}, {4'h0, exp});
        for (n = 0; n < 10 && ret_seen !== 1'b1; n++) @(negedge ref_clk_in);
        chk_bit(ret_seen, 1'b1);
        chk_bit(abrt_seen, 1'b1);
        chk_bit(stack_seen, 1'b0);
        abort_in = 1'b0;
        $display("test abort done");
    endtask

    // bill pulled from the mouth: refuses bills well after the event
    task automatic t_removal();
        int n;
        do_reset();
        insert_bill(3'h2);
        bill_removed_in = 1'b1;
        @(negedge ref_clk_in);
        bill_removed_in = 1'b0;
        for (n = 0; n < 10 && out_of_service_out !== 1'b1; n++) @(negedge ref_clk_in);
        chk_bit(out_of_service_out, 1'b1);
        repeat (1000) @(negedge ref_clk_in);
        chk_bit(out_of_service_out, 1'b1);
        chk_bit(bill_ready_out, 1'b0);
        chk_bit(stack_seen, 1'b0);
        $display("test removal done");
    endtask

    // reset in mid-pulse clears timers and lines; a fresh bill is taken
    task automatic t_reset();
        do_reset();
        insert_bill(3'h6);
        repeat (50) @(negedge ref_clk_in);
        do_reset();
        chk_vec(link_if.credit, 8'h00);
        chk_bit(out_of_service_out, 1'b0);
        insert_bill(3'h1);
        $display("test reset done");
    endtask

    // confirmed vend: first pulse width, stack on escrow, final pulse, escrow dropped
    task automatic t_vend();
        int n, w;
        do_reset();
        insert_bill(3'h3);
        for (w = 0; w < 300 && link_if.credit[3] === 1'b1; w++) @(negedge ref_clk_in);
        chk_bit(logic'(w >= BEH_PULSE_MS * TB_TICK), 1'b1);
        chk_bit(logic'(w <= (BEH_PULSE_MS + 2) * TB_TICK), 1'b1);
        chk_bit(stack_seen, 1'b0);
        vend_ok_in = 1'b1;
        for (n = 0; n < 20 && link_if.escrow !== 1'b1; n++) @(negedge ref_clk_in);
        chk_bit(link_if.escrow, 1'b1);
        vend_ok_in = 1'b0;
        for (n = 0; n < 20 && link_if.credit[3] !== 1'b1; n++) @(negedge ref_clk_in);
        chk_bit(stack_seen, 1'b1);
        chk_vec(link_if.credit, 8'h08);
        for (n = 0; n < 20 && done_seen !== 1'b1; n++) @(negedge ref_clk_in);
        chk_bit(done_seen, 1'b1);
        chk_bit(link_if.escrow, 1'b0);
        for (n = 0; n < 300 && bill_ready_out !== 1'b1; n++) @(negedge ref_clk_in);
        chk_bit(bill_ready_out, 1'b1);
        chk_bit(ret_seen, 1'b0);
        $display("test vend done");
    endtask

    // no confirmation: the held bill is returned at the escrow limit, never stacked
    task automatic t_timeout();
        int n;
        do_reset();
        insert_bill(3'h4);
        repeat (BEH_ESCROW_MS * TB_TICK - 500) @(negedge ref_clk_in);
        chk_bit(ret_seen, 1'b0);
        for (n = 0; n < 1000 && ret_seen !== 1'b1; n++) @(negedge ref_clk_in);
        chk_bit(ret_seen, 1'b1);
        chk_bit(stack_seen, 1'b0);
        $display("test timeout done");
    endtask

    initial
    begin
        t_modes();
        t_credit();
        t_abort(3'h1, 4'h2);
        t_abort(3'h5, 4'hF);
        t_removal();
        t_reset();
        t_vend();
        t_timeout();
        print_verdict();
    end
endmodule
